/* rtl/pir_pkg.sv */
// package: register map, field layout, reset values and types of the interval timer
package pir_pkg;

  localparam int unsigned PIR_ADDR_W = 16;
  localparam int unsigned PIR_DATA_W = 32;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] PIR_IDX_GATE = 12'hf76;
  localparam logic [11:0] PIR_IDX_CTRL = 12'hfc8;
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_GATE = {2'h0, PIR_IDX_GATE, 2'h0};
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_CTRL = {2'h0, PIR_IDX_CTRL, 2'h0};
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_STAT = 16'h0000;
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_CLR  = 16'h0004;
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_EN   = 16'h0008;
  localparam logic [PIR_ADDR_W-1:0] PIR_ADDR_CNT  = 16'h000c;

  // field positions
  localparam int unsigned PIR_GATE_EN_BIT = 5;
  localparam int unsigned PIR_RUN_BIT     = 0;
  localparam int unsigned PIR_SEL_LSB     = 1;
  localparam int unsigned PIR_SEL_W       = 3;
  localparam int unsigned PIR_EVT_BIT     = 0;

  // reset values
  localparam logic [7:0] PIR_GATE_RST = 8'h00;
  localparam logic [2:0] PIR_SEL_RST  = 3'h0;
  localparam logic       PIR_RUN_RST  = 1'b0;
  localparam logic       PIR_STAT_RST = 1'b0;
  localparam logic       PIR_EN_RST   = 1'b0;

  // interval counter: longest period is 2^15 low-frequency cycles
  localparam int unsigned PIR_CNT_W = 15;

  localparam logic [1:0] PIR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PIR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } pir_bus_e;

  typedef struct packed {
    logic [PIR_SEL_W-1:0] sel;
    logic                 run;
  } pir_ctrl_s;

  // low bits that must wrap to zero for the selected interval
  function automatic logic [PIR_CNT_W-1:0] pir_interval_mask(input logic [PIR_SEL_W-1:0] sel);
    logic [PIR_CNT_W-1:0] all_ones;
    all_ones = '1;
    pir_interval_mask = all_ones >> sel;
  endfunction : pir_interval_mask

endpackage : pir_pkg

/* rtl/pir_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pir_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pir_sync
`default_nettype wire

/* rtl/pir_top.sv */
// interval timer top: register slave, interval counter and interrupt logic
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - select code 0..7 gives 2^15..2^8 cycles
// - counter counts low-frequency edges while running
// - event at each interval, counter keeps going
// - run cleared: counter zeroed and halted
// - selection writes ignored while running
// - starting write may load selection, stopping not
// - run bit zero after reset
// - oscillator off, stop or sleep0 clear run
// - gate enable bit gates block operation
// - gate enable resets to zero
// - operates only while oscillator runs, not sleep0
module pir_top
  import pir_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  LF_CLK,
  input  wire logic                  LOW_OSC_EN,
  input  wire logic                  STOP_MODE,
  input  wire logic                  SLEEP0_MODE,
  input  wire logic [PIR_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output var  logic                  S_AXI_AWREADY,
  input  wire logic [PIR_DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output var  logic                  S_AXI_WREADY,
  output var  logic [1:0]            S_AXI_BRESP,
  output var  logic                  S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [PIR_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output var  logic                  S_AXI_ARREADY,
  output var  logic [PIR_DATA_W-1:0] S_AXI_RDATA,
  output var  logic [1:0]            S_AXI_RRESP,
  output var  logic                  S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  output var  logic                  INTERVAL_IRQ,
  output var  logic                  IRQ
);

  // pin synchronisation
  logic [3:0]            pin_s;
  logic                  lf_s;
  logic                  osc_en_s;
  logic                  stop_s;
  logic                  sleep0_s;
  logic                  lf_prev_r;
  logic                  lf_rise;

  // write channel
  pir_bus_e              wr_state_r;
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [PIR_ADDR_W-1:0] awaddr_r;
  logic [PIR_DATA_W-1:0] wdata_r;
  logic [3:0]            wstrb_r;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  wr_fire;
  logic                  wr_lo;
  logic                  wr_hit;
  logic                  wr_gate;
  logic                  wr_ctrl;
  logic                  wr_clr;
  logic                  wr_en;

  // read channel
  pir_bus_e              rd_state_r;
  logic                  ar_hs;
  logic                  rd_hit;
  logic [PIR_DATA_W-1:0] rd_data;

  // block state
  logic [7:0]            gate_r;
  logic                  gate_en;
  pir_ctrl_s             ctrl_r;
  pir_ctrl_s             ctrl_nxt;
  logic                  sel_load;
  logic                  stop_req;
  logic                  cnt_ok;
  logic                  cnt_step;
  logic [PIR_CNT_W-1:0]  cnt_r;
  logic [PIR_CNT_W-1:0]  cnt_inc;
  logic [PIR_CNT_W-1:0]  cnt_nxt;
  logic                  tick;
  logic                  stat_r;
  logic                  stat_nxt;
  logic                  en_r;

  // low-frequency clock is sampled as a level, never used as a clock edge
  pir_sync #(
    .W (4)
  ) u_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({SLEEP0_MODE, STOP_MODE, LOW_OSC_EN, LF_CLK}),
    .q     (pin_s)
  );

  assign lf_s     = pin_s[0];
  assign osc_en_s = pin_s[1];
  assign stop_s   = pin_s[2];
  assign sleep0_s = pin_s[3];
  assign lf_rise  = lf_s & ~lf_prev_r;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lf_prev_r <= 1'b0;
    end else begin
      lf_prev_r <= lf_s;
    end
  end

  // write address and data are taken independently, in either order
  assign aw_hs   = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs    = S_AXI_WVALID & S_AXI_WREADY;
  assign wr_fire = (wr_state_r == BUS_IDLE) & aw_held_r & w_held_r;
  assign wr_lo   = wr_fire & wstrb_r[0];
  assign wr_hit  = (awaddr_r == PIR_ADDR_GATE) | (awaddr_r == PIR_ADDR_CTRL)
                 | (awaddr_r == PIR_ADDR_STAT) | (awaddr_r == PIR_ADDR_CLR)
                 | (awaddr_r == PIR_ADDR_EN)   | (awaddr_r == PIR_ADDR_CNT);
  assign wr_gate = wr_lo & (awaddr_r == PIR_ADDR_GATE);
  assign wr_ctrl = wr_lo & (awaddr_r == PIR_ADDR_CTRL) & gate_en;
  assign wr_clr  = wr_lo & (awaddr_r == PIR_ADDR_CLR);
  assign wr_en   = wr_lo & (awaddr_r == PIR_ADDR_EN);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_state_r    <= BUS_IDLE;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= PIR_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_hs) begin
        w_held_r     <= 1'b1;
        wdata_r      <= S_AXI_WDATA;
        wstrb_r      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      case (wr_state_r)
        BUS_IDLE: begin
          if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? PIR_RESP_OKAY : PIR_RESP_SLVERR;
            wr_state_r   <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID  <= 1'b0;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            wr_state_r    <= BUS_IDLE;
          end
        end
        default: begin
          wr_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // read data is captured at the address handshake
  assign ar_hs  = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_hit = (S_AXI_ARADDR == PIR_ADDR_GATE) | (S_AXI_ARADDR == PIR_ADDR_CTRL)
                | (S_AXI_ARADDR == PIR_ADDR_STAT) | (S_AXI_ARADDR == PIR_ADDR_CLR)
                | (S_AXI_ARADDR == PIR_ADDR_EN)   | (S_AXI_ARADDR == PIR_ADDR_CNT);
  assign rd_data =
      (S_AXI_ARADDR == PIR_ADDR_GATE) ? {24'h0, gate_r} :
      (S_AXI_ARADDR == PIR_ADDR_CTRL) ? {28'h0, ctrl_r.sel, ctrl_r.run} :
      (S_AXI_ARADDR == PIR_ADDR_STAT) ? {31'h0, stat_r} :
      (S_AXI_ARADDR == PIR_ADDR_EN)   ? {31'h0, en_r} :
      (S_AXI_ARADDR == PIR_ADDR_CNT)  ? {17'h0, cnt_r} :
      32'h0;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_state_r    <= BUS_IDLE;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= PIR_RESP_OKAY;
    end else begin
      case (rd_state_r)
        BUS_IDLE: begin
          if (ar_hs) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_data;
            S_AXI_RRESP   <= rd_hit ? PIR_RESP_OKAY : PIR_RESP_SLVERR;
            rd_state_r    <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
            rd_state_r    <= BUS_IDLE;
          end
        end
        default: begin
          rd_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // gate register: all eight bits stored, bit 5 enables the timer
  assign gate_en = gate_r[PIR_GATE_EN_BIT];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_r <= PIR_GATE_RST;
    end else if (wr_gate) begin
      gate_r <= wdata_r[7:0];
    end
  end

  // selection loads only while stopped, so a stopping write keeps it
  assign sel_load = wr_ctrl & ~ctrl_r.run;
  // hardware stop acts only while running, so a software start in the same cycle wins and is cleared a cycle later
  assign stop_req = ctrl_r.run & (~osc_en_s | stop_s | sleep0_s);

  assign ctrl_nxt.sel = sel_load ? wdata_r[PIR_SEL_LSB +: PIR_SEL_W] : ctrl_r.sel;
  assign ctrl_nxt.run = stop_req ? 1'b0 :
                        wr_ctrl  ? wdata_r[PIR_RUN_BIT] : ctrl_r.run;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r.sel <= PIR_SEL_RST;
      ctrl_r.run <= PIR_RUN_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // interval counter; gate off freezes it rather than cutting a real clock
  assign cnt_ok   = gate_en & osc_en_s & ~stop_s & ~sleep0_s;
  assign cnt_step = ctrl_r.run & lf_rise & cnt_ok;
  assign cnt_inc  = cnt_r + 15'h0001;
  assign cnt_nxt  = ~ctrl_r.run ? '0 : cnt_step ? cnt_inc : cnt_r;
  // all periods divide 2^15, so wrap-around keeps every interval exact
  assign tick     = cnt_step & ((cnt_inc & pir_interval_mask(ctrl_r.sel)) == '0);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  assign stat_nxt = tick | (stat_r & ~(wr_clr & wdata_r[PIR_EVT_BIT]));

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r       <= PIR_STAT_RST;
      en_r         <= PIR_EN_RST;
      INTERVAL_IRQ <= 1'b0;
      IRQ          <= 1'b0;
    end else begin
      stat_r       <= stat_nxt;
      INTERVAL_IRQ <= tick;
      IRQ          <= stat_r & en_r;
      if (wr_en) begin
        en_r <= wdata_r[PIR_EVT_BIT];
      end
    end
  end

endmodule : pir_top
`default_nettype wire

/* tb/pir_top_asserts.sv */
// checker: bus timing and interrupt behaviour of the interval timer
`timescale 1ns/1ns
`default_nettype none
module pir_asserts
  import pir_pkg::*;
(
  input wire logic                  REF_CLK,
  input wire logic                  RST_N,
  input wire logic                  LOW_OSC_EN,
  input wire logic                  STOP_MODE,
  input wire logic                  SLEEP0_MODE,
  input wire logic                  S_AXI_AWVALID,
  input wire logic                  S_AXI_AWREADY,
  input wire logic                  S_AXI_WVALID,
  input wire logic                  S_AXI_WREADY,
  input wire logic                  S_AXI_BVALID,
  input wire logic [PIR_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic                  S_AXI_ARVALID,
  input wire logic                  S_AXI_ARREADY,
  input wire logic [PIR_DATA_W-1:0] S_AXI_RDATA,
  input wire logic                  S_AXI_RVALID,
  input wire logic                  INTERVAL_IRQ,
  input wire logic                  IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_ctl_read;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == PIR_ADDR_CTRL;
  endsequence
  a_wr_resp_time: assert property (s_wr_take |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response not two cycles after request");
  a_rd_resp_time: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data not one cycle after request");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channel ready while response pending");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready while data pending");
  a_ctrl_high_zero: assert property (s_ctl_read |=> S_AXI_RDATA[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_irq_single: assert property (INTERVAL_IRQ |=> !INTERVAL_IRQ)
    else $error("interval pulse longer than one cycle");
  a_stop_quiet: assert property (STOP_MODE [*8] |=> !INTERVAL_IRQ)
    else $error("interval event during stop");
  a_sleep_quiet: assert property (SLEEP0_MODE [*8] |=> !INTERVAL_IRQ)
    else $error("interval event during sleep0");
  a_osc_quiet: assert property (!LOW_OSC_EN [*8] |=> !INTERVAL_IRQ)
    else $error("interval event with oscillator off");
  a_irq_reset: assert property ($rose(RST_N) |-> !IRQ && !INTERVAL_IRQ)
    else $error("interrupt active at reset release");
endmodule : pir_asserts
bind pir_top pir_asserts u_chk (
  .REF_CLK, .RST_N, .LOW_OSC_EN, .STOP_MODE, .SLEEP0_MODE, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .INTERVAL_IRQ, .IRQ
);
`default_nettype wire

/* tb/tb.sv */
// testbench: register, interval and interrupt scenarios for the interval timer
`timescale 1ns/1ns
`default_nettype none
module tb
  import pir_pkg::*;
;
  typedef struct packed {
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  r;
  } pir_row_s;
  logic        clk, rst_n, lf, osc, stop, slp, awv, wv, bry, arv, rry;
  logic        awrdy, wrdy, bv, arrdy, rv, iirq, irq;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat, got;
  logic [1:0]  br, rr, resp;
  logic [2:0]  sel;
  int          miscompares, check_count, lf_cnt;
  pir_row_s    rows [7] = '{
    '{PIR_ADDR_CTRL, 32'h3, 32'h0, PIR_RESP_OKAY},
    '{PIR_ADDR_GATE, 32'h21, 32'h21, PIR_RESP_OKAY},
    '{PIR_ADDR_CTRL, 32'hfe, 32'he, PIR_RESP_OKAY},
    '{16'h0100, 32'hff, 32'h0, PIR_RESP_SLVERR},
    '{PIR_ADDR_STAT, 32'h1, 32'h0, PIR_RESP_OKAY},
    '{PIR_ADDR_CNT, 32'h5, 32'h0, PIR_RESP_OKAY},
    '{PIR_ADDR_EN, 32'h1, 32'h1, PIR_RESP_OKAY}
  };
  // strobes tied: byte lane 0 carries every field
  pir_top DUT (
    .REF_CLK(clk), .RST_N(rst_n), .LF_CLK(lf), .LOW_OSC_EN(osc), .STOP_MODE(stop),
    .SLEEP0_MODE(slp), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .INTERVAL_IRQ(iirq), .IRQ(irq)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // slow clock of 16 cycles, slow enough for the input synchroniser
  always begin
    repeat (8) @(posedge clk);
    lf <= ~lf;
    if (!lf) lf_cnt++;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    got = rdat;
    resp = rr;
    rry <= 1'b0;
    chk("rdata", e, got);
  endtask : rdc
  // waits for one interval pulse, bounded by the longest tested period
  task automatic wait_evt();
    int n;
    n = 0;
    while (iirq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("event", 32'h1, {31'h0, iirq});
    @(posedge clk);
  endtask : wait_evt
  initial begin
    {rst_n, lf, osc, stop, slp, awv, wv, bry, arv, rry} = 10'b0010000000;
    {awa, ara, wd} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(PIR_ADDR_CTRL, 32'h0);
    rdc(PIR_ADDR_GATE, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", 32'(rows[i].r), 32'(resp));
      rdc(rows[i].a, rows[i].q);
      chk("rresp", 32'(rows[i].r), 32'(resp));
    end
    $display("test registers done");
    for (int s = 7; s >= 5; s--) begin
      sel = s[2:0];
      wr(PIR_ADDR_CTRL, {28'h0, sel, 1'b1});
      wait_evt();
      lf_cnt = 0;
      wait_evt();
      chk("period", 32'h1 << (15 - s), 32'(lf_cnt));
      chk("irq", 32'h1, {31'h0, irq});
      wr(PIR_ADDR_CTRL, {28'h0, ~sel, 1'b1});
      rdc(PIR_ADDR_CTRL, {28'h0, sel, 1'b1});
      wr(PIR_ADDR_CTRL, {28'h0, ~sel, 1'b0});
      rdc(PIR_ADDR_CTRL, {28'h0, sel, 1'b0});
      rdc(PIR_ADDR_CNT, 32'h0);
      wr(PIR_ADDR_CLR, 32'h1);
      rdc(PIR_ADDR_STAT, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test interval done");
    end
    for (int k = 0; k < 3; k++) begin
      wr(PIR_ADDR_CTRL, 32'hf);
      {osc, stop, slp} <= 3'b100 ^ (3'b100 >> k);
      repeat (8) @(posedge clk);
      {osc, stop, slp} <= 3'b100;
      rdc(PIR_ADDR_CTRL, 32'he);
    end
    $display("test hardware stop done");
    wr(PIR_ADDR_EN, 32'h0);
    wr(PIR_ADDR_CTRL, 32'hf);
    wait_evt();
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(PIR_ADDR_STAT, 32'h1);
    wr(PIR_ADDR_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PIR_ADDR_CTRL, 32'h0);
    wr(PIR_ADDR_CLR, 32'h1);
    rdc(PIR_ADDR_STAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // reset in mid-run: run, enable and gate must all come back cleared
    wr(PIR_ADDR_CTRL, 32'hf);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(PIR_ADDR_CTRL, 32'h0);
    rdc(PIR_ADDR_GATE, 32'h0);
    rdc(PIR_ADDR_EN, 32'h0);
    rdc(PIR_ADDR_CNT, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
  // run needs about 62000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
